// *** logic/isf_pkg.sv ***
// Constants, encodings and register map shared by both ends of the interrupt block
package isf_pkg;
	localparam int PC_W = 13;
	localparam logic [12:0] RESET_VEC = 13'h0000;
	localparam logic [12:0] INT_VEC = 13'h0004;
	// Quarter phases, one hclk each
	localparam logic [1:0] Q1 = 2'h0;
	localparam logic [1:0] Q4 = 2'h3;
	localparam int HCLK_NS = 8;
	localparam int INSTR_CYCLE_TIME_NS = 32;
	localparam int INSTR_CYCLES = INSTR_CYCLE_TIME_NS / HCLK_NS;
	// Device register indices on the core port
	localparam logic [3:0] A_INT_CTRL = 4'h0;
	localparam logic [3:0] A_FLAGS1 = 4'h1;
	localparam logic [3:0] A_FLAGS2 = 4'h2;
	localparam logic [3:0] A_ENAB1 = 4'h3;
	localparam logic [3:0] A_ENAB2 = 4'h4;
	localparam logic [3:0] A_RXDATA = 4'h5;
	// int_control_reg bits
	localparam int B_GLOBAL_EN = 7;
	localparam int B_GROUP_EN = 6;
	localparam int B_INTE = 4;
	localparam int B_PIN_FLAG = 1;
	// periph_flags_1 bits
	localparam int B_T1G = 7;
	localparam int B_ADC = 6;
	localparam int B_RX = 5;
	localparam int B_TX = 4;
	localparam int B_SSP = 3;
	localparam int B_CCP = 2;
	localparam int B_T2 = 1;
	localparam int B_T1 = 0;
	localparam logic [7:0] FLAGS1_STICKY = 8'h4F;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [1:0] CCP_CAPTURE = 2'h0;
	localparam logic [1:0] CCP_COMPARE = 2'h1;
	// Host AHB-Lite register byte offsets
	localparam logic [7:0] H_ACCESS = 8'h00;
	localparam logic [7:0] H_OP = 8'h04;
	localparam logic [7:0] H_EVENTS = 8'h08;
	localparam logic [7:0] H_LEVELS = 8'h0C;
	localparam logic [7:0] H_STATUS = 8'h10;
	typedef enum logic [2:0] {
		ST_RUN = 3'h0,
		ST_VEC = 3'h1,
		ST_FLUSH = 3'h2,
		ST_SLEEP = 3'h3,
		ST_WAKE = 3'h4
	} isf_state_e;
	typedef enum logic [1:0] {
		OP_STEP = 2'h0,
		OP_RET = 2'h1,
		OP_SLEEP = 2'h2
	} isf_op_e;
endpackage

// *** logic/isf_if.sv ***
// Link between the interrupt sequencer and the core/peripheral side
`timescale 1ns/1ps
interface isf_if;
	logic [3:0] reg_addr;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [1:0] q_phase;
	logic [12:0] pc;
	logic exec_valid;
	logic irq_taken;
	logic sleeping;
	logic [1:0] op;
	logic ext_pin;
	logic t1_gate_active;
	logic adc_done;
	logic rx_full;
	logic rx_rd;
	logic [7:0] rx_byte;
	logic tx_empty;
	logic ssp_done;
	logic ccp_capture;
	logic ccp_compare;
	logic [1:0] ccp_mode;
	logic t2_match;
	logic t1_ovf;
	logic [7:0] evt2;
	modport dev(input reg_addr, reg_wr, reg_rd, reg_wdata, op, ext_pin, t1_gate_active, adc_done, rx_full,
		rx_byte, tx_empty, ssp_done, ccp_capture, ccp_compare, ccp_mode, t2_match, t1_ovf, evt2,
		output reg_rdata, q_phase, pc, exec_valid, irq_taken, sleeping, rx_rd);
	modport host(output reg_addr, reg_wr, reg_rd, reg_wdata, op, ext_pin, t1_gate_active, adc_done, rx_full,
		rx_byte, tx_empty, ssp_done, ccp_capture, ccp_compare, ccp_mode, t2_match, t1_ovf, evt2,
		input reg_rdata, q_phase, pc, exec_valid, irq_taken, sleeping, rx_rd);
endinterface

// *** logic/isf_dev.sv ***
// Interrupt flags, enables and vectoring sequencer of the core
`timescale 1ns/1ps
module isf_dev #(
	parameter int STACK_DEPTH = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	isf_if.dev lnk
);
	localparam int SP_W = $clog2(STACK_DEPTH);

	// Refused at elaboration: the stack pointer wraps by its bit width
	if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_depth_check
		$error("STACK_DEPTH must be a power of two, at least 2");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [1:0] q_reg, q_next;
	logic [2:0] pin_sync_reg, pin_sync_next;
	logic pin_lvl_reg, pin_lvl_next;
	logic pin_pend_reg, pin_pend_next;
	logic global_en_reg, global_en_next;
	logic group_en_reg, group_en_next;
	logic inte_reg, inte_next;
	logic pin_flag_reg, pin_flag_next;
	logic [7:0] flags1_reg, flags1_next;
	logic [7:0] flags2_reg, flags2_next;
	logic [7:0] enab1_reg, enab1_next;
	logic [7:0] enab2_reg, enab2_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rx_rd_reg, rx_rd_next;
	isf_pkg::isf_state_e state_reg, state_next;
	logic [12:0] pc_reg, pc_next;
	logic [SP_W-1:0] sp_reg, sp_next;
	logic exec_reg, exec_next;
	logic taken_reg, taken_next;
	logic sleep_reg, sleep_next;
	logic [12:0] stack_mem [STACK_DEPTH];

	logic q1, q4, pin_rise, pin_flag_set, ccp_set, any_en, irq, push;
	logic [7:0] flags1_view, set1;
	logic [12:0] pc_inc;

	// ----------------------------------------
	// Flags, enables and register port
	// ----------------------------------------
	always_comb begin
		q_next = q_reg + 2'h1;
		q1 = q_reg == isf_pkg::Q1;
		q4 = q_reg == isf_pkg::Q4;
		// Only the second and third stages are looked at
		pin_sync_next = {pin_sync_reg[1:0], lnk.ext_pin};
		pin_lvl_next = (pin_sync_reg[1] == pin_sync_reg[2]) ? pin_sync_reg[2] : pin_lvl_reg;
		pin_rise = pin_sync_reg[1] & pin_sync_reg[2] & ~pin_lvl_reg;
		// Edge waits for the Q4-Q1 window before the flag may set
		pin_flag_set = (pin_pend_reg | pin_rise) & (q4 | q1);
		pin_pend_next = (pin_pend_reg | pin_rise) & ~(q4 | q1);
		// Compare flag only in compare mode, capture only in capture, none in PWM
		ccp_set = (lnk.ccp_capture && lnk.ccp_mode == isf_pkg::CCP_CAPTURE) ||
			(lnk.ccp_compare && lnk.ccp_mode == isf_pkg::CCP_COMPARE);
		set1 = 8'h00;
		set1[isf_pkg::B_ADC] = lnk.adc_done;
		set1[isf_pkg::B_SSP] = lnk.ssp_done;
		set1[isf_pkg::B_CCP] = ccp_set;
		set1[isf_pkg::B_T2] = lnk.t2_match;
		set1[isf_pkg::B_T1] = lnk.t1_ovf;
		flags1_view = flags1_reg;
		flags1_view[isf_pkg::B_T1G] = ~lnk.t1_gate_active;
		flags1_view[isf_pkg::B_RX] = lnk.rx_full;
		flags1_view[isf_pkg::B_TX] = lnk.tx_empty;

		group_en_next = group_en_reg;
		inte_next = inte_reg;
		pin_flag_next = pin_flag_reg | pin_flag_set;
		flags1_next = flags1_reg | set1;
		flags2_next = flags2_reg | lnk.evt2;
		enab1_next = enab1_reg;
		enab2_next = enab2_reg;
		global_en_next = global_en_reg;
		if (lnk.reg_wr) begin
			case (lnk.reg_addr)
				isf_pkg::A_INT_CTRL: begin
					global_en_next = lnk.reg_wdata[isf_pkg::B_GLOBAL_EN];
					group_en_next = lnk.reg_wdata[isf_pkg::B_GROUP_EN];
					inte_next = lnk.reg_wdata[isf_pkg::B_INTE];
					pin_flag_next = lnk.reg_wdata[isf_pkg::B_PIN_FLAG] | pin_flag_set;
				end
				// A hardware set in the same cycle as a clear wins
				isf_pkg::A_FLAGS1: flags1_next = (lnk.reg_wdata & isf_pkg::FLAGS1_STICKY) | set1;
				isf_pkg::A_FLAGS2: flags2_next = lnk.reg_wdata | lnk.evt2;
				isf_pkg::A_ENAB1: enab1_next = lnk.reg_wdata;
				isf_pkg::A_ENAB2: enab2_next = lnk.reg_wdata;
				default: ;
			endcase
		end

		rx_rd_next = lnk.reg_rd && lnk.reg_addr == isf_pkg::A_RXDATA;
		rdata_next = rdata_reg;
		if (lnk.reg_rd) begin
			case (lnk.reg_addr)
				isf_pkg::A_INT_CTRL: begin
					rdata_next = 8'h00;
					rdata_next[isf_pkg::B_GLOBAL_EN] = global_en_reg;
					rdata_next[isf_pkg::B_GROUP_EN] = group_en_reg;
					rdata_next[isf_pkg::B_INTE] = inte_reg;
					rdata_next[isf_pkg::B_PIN_FLAG] = pin_flag_reg;
				end
				isf_pkg::A_FLAGS1: rdata_next = flags1_view;
				isf_pkg::A_FLAGS2: rdata_next = flags2_reg;
				isf_pkg::A_ENAB1: rdata_next = enab1_reg;
				isf_pkg::A_ENAB2: rdata_next = enab2_reg;
				isf_pkg::A_RXDATA: rdata_next = lnk.rx_byte;
				default: rdata_next = 8'h00;
			endcase
		end

		// ----------------------------------------
		// Request and sequencing
		// ----------------------------------------
		any_en = (inte_reg & pin_flag_reg) |
			(group_en_reg & (|(flags1_view & enab1_reg) | |(flags2_reg & enab2_reg)));
		irq = global_en_reg & any_en;
		pc_inc = pc_reg + 13'h0001;
		state_next = state_reg;
		pc_next = pc_reg;
		sp_next = sp_reg;
		push = 1'b0;
		taken_next = 1'b0;
		case (state_reg)
			isf_pkg::ST_RUN: begin
				if (q1 && irq) begin
					// Decided at Q1 whatever the instruction's length
					state_next = isf_pkg::ST_VEC;
				end else if (q4) begin
					case (lnk.op)
						isf_pkg::OP_RET: begin
							sp_next = sp_reg - 1'b1;
							pc_next = stack_mem[sp_reg - 1'b1];
							global_en_next = 1'b1;
							state_next = isf_pkg::ST_FLUSH;
						end
						isf_pkg::OP_SLEEP: begin
							pc_next = pc_inc;
							state_next = isf_pkg::ST_SLEEP;
						end
						default: pc_next = pc_inc;
					endcase
				end
			end
			isf_pkg::ST_VEC, isf_pkg::ST_WAKE: begin
				if (q4) begin
					// Prefetched instruction is dropped by the flush cycle
					push = 1'b1;
					sp_next = sp_reg + 1'b1;
					pc_next = isf_pkg::INT_VEC;
					global_en_next = 1'b0;
					taken_next = 1'b1;
					state_next = isf_pkg::ST_FLUSH;
				end
			end
			isf_pkg::ST_FLUSH: begin
				if (q4) begin
					pc_next = pc_inc;
					state_next = isf_pkg::ST_RUN;
				end
			end
			isf_pkg::ST_SLEEP: begin
				if (q4 && any_en) begin
					state_next = global_en_reg ? isf_pkg::ST_WAKE : isf_pkg::ST_RUN;
				end
			end
			default: state_next = isf_pkg::ST_RUN;
		endcase
		exec_next = state_next == isf_pkg::ST_RUN || state_next == isf_pkg::ST_VEC ||
			state_next == isf_pkg::ST_WAKE;
		sleep_next = state_next == isf_pkg::ST_SLEEP;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q_reg <= isf_pkg::Q1;
			pin_sync_reg <= 3'h0;
			pin_lvl_reg <= 1'b0;
			pin_pend_reg <= 1'b0;
			global_en_reg <= 1'b0;
			group_en_reg <= 1'b0;
			inte_reg <= 1'b0;
			pin_flag_reg <= 1'b0;
			flags1_reg <= isf_pkg::REG_RST;
			flags2_reg <= isf_pkg::REG_RST;
			enab1_reg <= isf_pkg::REG_RST;
			enab2_reg <= isf_pkg::REG_RST;
			rdata_reg <= isf_pkg::REG_RST;
			rx_rd_reg <= 1'b0;
			state_reg <= isf_pkg::ST_RUN;
			pc_reg <= isf_pkg::RESET_VEC;
			sp_reg <= '0;
			exec_reg <= 1'b1;
			taken_reg <= 1'b0;
			sleep_reg <= 1'b0;
		end else begin
			q_reg <= q_next;
			pin_sync_reg <= pin_sync_next;
			pin_lvl_reg <= pin_lvl_next;
			pin_pend_reg <= pin_pend_next;
			global_en_reg <= global_en_next;
			group_en_reg <= group_en_next;
			inte_reg <= inte_next;
			pin_flag_reg <= pin_flag_next;
			flags1_reg <= flags1_next;
			flags2_reg <= flags2_next;
			enab1_reg <= enab1_next;
			enab2_reg <= enab2_next;
			rdata_reg <= rdata_next;
			rx_rd_reg <= rx_rd_next;
			state_reg <= state_next;
			pc_reg <= pc_next;
			sp_reg <= sp_next;
			exec_reg <= exec_next;
			taken_reg <= taken_next;
			sleep_reg <= sleep_next;
		end
	end

	// Return stack wraps on overflow, as a circular buffer
	always_ff @(posedge hclk) begin
		if (push) begin
			stack_mem[sp_reg] <= pc_inc;
		end
	end

	assign lnk.q_phase = q_reg;
	assign lnk.pc = pc_reg;
	assign lnk.exec_valid = exec_reg;
	assign lnk.irq_taken = taken_reg;
	assign lnk.sleeping = sleep_reg;
	assign lnk.reg_rdata = rdata_reg;
	assign lnk.rx_rd = rx_rd_reg;
endmodule

// *** logic/isf_host.sv ***
// Core and peripheral side: drives events and core orders from AHB-Lite registers
`timescale 1ns/1ps
module isf_host (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	isf_if.host lnk
);
	// ----------------------------------------
	// AHB-Lite slave and order registers
	// ----------------------------------------
	logic wr_pend_reg, wr_pend_next;
	logic [7:0] wr_addr_reg, wr_addr_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic [3:0] raddr_reg, raddr_next;
	logic rd_reg, rd_next;
	logic wr_reg, wr_next;
	logic [7:0] wdata_reg, wdata_next;
	logic rd_dly_reg, rd_dly_next;
	logic [7:0] rback_reg, rback_next;
	logic [1:0] op_reg, op_next;
	logic [13:0] ev_reg, ev_next;
	logic [15:0] lvl_reg, lvl_next;
	logic take;

	always_comb begin
		take = hsel && htrans[1] && hready;
		wr_pend_next = take && hwrite;
		wr_addr_next = take ? haddr[7:0] : wr_addr_reg;
		raddr_next = raddr_reg;
		wdata_next = wdata_reg;
		rd_next = 1'b0;
		wr_next = 1'b0;
		ev_next = 14'h0000;
		op_next = op_reg;
		lvl_next = lvl_reg;
		// Receive buffer empties when the core reads its data
		if (lnk.rx_rd) begin
			lvl_next[2] = 1'b0;
		end
		// Order is used once, then the core steps again
		if (lnk.q_phase == isf_pkg::Q4 && lnk.exec_valid) begin
			op_next = isf_pkg::OP_STEP;
		end
		if (wr_pend_reg) begin
			case (wr_addr_reg)
				isf_pkg::H_ACCESS: begin
					raddr_next = hwdata[3:0];
					wdata_next = hwdata[15:8];
					wr_next = hwdata[16];
					rd_next = hwdata[17];
				end
				isf_pkg::H_OP: op_next = hwdata[1:0];
				isf_pkg::H_EVENTS: ev_next = hwdata[13:0];
				isf_pkg::H_LEVELS: lvl_next = hwdata[15:0];
				default: ;
			endcase
		end
		rd_dly_next = rd_reg;
		rback_next = rd_dly_reg ? lnk.reg_rdata : rback_reg;
		hrdata_next = 32'h0000_0000;
		if (take && !hwrite) begin
			case (haddr[7:0])
				isf_pkg::H_OP: hrdata_next = {30'h0000_0000, op_reg};
				isf_pkg::H_LEVELS: hrdata_next = {16'h0000, lvl_reg};
				isf_pkg::H_STATUS: hrdata_next = {rback_reg, 4'h0, lnk.q_phase, lnk.sleeping,
					lnk.exec_valid, 3'h0, lnk.pc};
				default: hrdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata_reg <= 32'h0000_0000;
			raddr_reg <= 4'h0;
			rd_reg <= 1'b0;
			wr_reg <= 1'b0;
			wdata_reg <= 8'h00;
			rd_dly_reg <= 1'b0;
			rback_reg <= 8'h00;
			op_reg <= isf_pkg::OP_STEP;
			ev_reg <= 14'h0000;
			lvl_reg <= 16'h0000;
		end else begin
			wr_pend_reg <= wr_pend_next;
			wr_addr_reg <= wr_addr_next;
			hrdata_reg <= hrdata_next;
			raddr_reg <= raddr_next;
			rd_reg <= rd_next;
			wr_reg <= wr_next;
			wdata_reg <= wdata_next;
			rd_dly_reg <= rd_dly_next;
			rback_reg <= rback_next;
			op_reg <= op_next;
			ev_reg <= ev_next;
			lvl_reg <= lvl_next;
		end
	end

	// Zero wait states: every transfer completes in its first data phase
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign lnk.reg_addr = raddr_reg;
	assign lnk.reg_wr = wr_reg;
	assign lnk.reg_rd = rd_reg;
	assign lnk.reg_wdata = wdata_reg;
	assign lnk.op = op_reg;
	assign lnk.adc_done = ev_reg[0];
	assign lnk.ssp_done = ev_reg[1];
	assign lnk.ccp_capture = ev_reg[2];
	assign lnk.ccp_compare = ev_reg[3];
	assign lnk.t2_match = ev_reg[4];
	assign lnk.t1_ovf = ev_reg[5];
	assign lnk.evt2 = ev_reg[13:6];
	assign lnk.ext_pin = lvl_reg[0];
	assign lnk.t1_gate_active = lvl_reg[1];
	assign lnk.rx_full = lvl_reg[2];
	assign lnk.tx_empty = lvl_reg[3];
	assign lnk.ccp_mode = lvl_reg[5:4];
	assign lnk.rx_byte = lvl_reg[15:8];
endmodule

// *** tb/isf_link_asserts.sv ***
// Concurrent checks on the link between the interrupt sequencer and the core side
`timescale 1ns/1ps
module isf_link_asserts (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [3:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [1:0] q_phase,
	input wire logic [12:0] pc,
	input wire logic exec_valid,
	input wire logic irq_taken,
	input wire logic sleeping,
	input wire logic rx_rd
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// ----------------------------------------
	// Sequencing
	// ----------------------------------------
	a_phase_advance: assert property (hresetn |=> q_phase == $past(q_phase) + 2'h1)
		else $error("quarter phase did not advance by one");
	a_vector_addr: assert property (irq_taken |-> pc == isf_pkg::INT_VEC)
		else $error("vector taken to wrong address");
	a_take_at_q4: assert property (irq_taken |-> q_phase == isf_pkg::Q1 && $past(q_phase) == isf_pkg::Q4)
		else $error("vector taken off the instruction boundary");
	a_flush_then_vec: assert property (irq_taken |-> !exec_valid ##4 (exec_valid && pc == isf_pkg::INT_VEC + 13'h1))
		else $error("flush cycle or vector execute misplaced");
	a_single_take: assert property (irq_taken |=> !irq_taken [*8])
		else $error("vector taken again with global enable cleared");
	a_pc_at_q4: assert property ($changed(pc) |-> $past(q_phase) == isf_pkg::Q4)
		else $error("program counter moved inside an instruction cycle");
	a_no_vec_asleep: assert property (sleeping |-> !irq_taken)
		else $error("vector taken while asleep");
	// A read of the receive data is what empties the receive buffer
	a_rx_read_cause: assert property (rx_rd |-> $past(reg_rd) && $past(reg_addr) == isf_pkg::A_RXDATA)
		else $error("receive read strobe without a receive data read");
	a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
		else $error("read data changed without a read");
	c_vector: cover property (irq_taken);
	c_wake: cover property (sleeping ##1 !sleeping);
	c_rx_read: cover property (rx_rd);
endmodule

// *** tb/test_interrupt_sequencing_and_flags.sv ***
// Self-checking bench: AHB-Lite host end driving the interrupt sequencer
`timescale 1ns/1ps
module test_interrupt_sequencing_and_flags;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hready;
	logic [31:0] hrdata;
	logic [31:0] r;
	logic [7:0] v;
	int failures = 0;
	int check_count = 0;
	int irq_cnt = 0;
	int i;
	isf_if lnk();
	isf_dev isf_dev_inst (.hclk(hclk), .hresetn(hresetn), .lnk(lnk));
	isf_host isf_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
		.hresp(), .hrdata(hrdata), .lnk(lnk));
	isf_link_asserts isf_link_asserts_inst (.hclk(hclk), .hresetn(hresetn), .reg_addr(lnk.reg_addr),
		.reg_rd(lnk.reg_rd), .reg_rdata(lnk.reg_rdata), .q_phase(lnk.q_phase), .pc(lnk.pc),
		.exec_valid(lnk.exec_valid), .irq_taken(lnk.irq_taken), .sleeping(lnk.sleeping), .rx_rd(lnk.rx_rd));
	initial begin
		forever #4 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		if (lnk.irq_taken === 1'b1) begin
			irq_cnt <= irq_cnt + 1;
		end
	end
	// ----------------------------------------
	// Bus and device access
	// ----------------------------------------
	task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask
	task automatic dwr(input logic [3:0] idx, input logic [7:0] d);
		ahb(isf_pkg::H_ACCESS, 1'b1, {14'h0, 2'h1, d, 4'h0, idx});
	endtask
	// Device read lands in the status word two edges after the access write completes
	task automatic drd(input logic [3:0] idx);
		ahb(isf_pkg::H_ACCESS, 1'b1, {14'h0, 2'h2, 8'h00, 4'h0, idx});
		repeat (3) @(posedge hclk);
		ahb(isf_pkg::H_STATUS, 1'b0, 32'h0);
		v = r[31:24];
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wirq(input int n);
		int k;
		for (k = 0; k < 300 && irq_cnt != n; k++) @(posedge hclk);
		chk(irq_cnt, n);
	endtask
	task print_verdict;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Whole sequence needs a few hundred cycles; this leaves ample margin
	initial begin
		#100000;
		failures++;
		print_verdict;
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(isf_pkg::H_STATUS, 1'b0, 32'h0);
		chk({r[17:16], r[12:0]}, {2'b01, isf_pkg::RESET_VEC});
		for (i = 0; i < 5; i++) begin
			drd(4'(i));
			chk(v, (i == 1) ? 8'h80 : 8'h00);
		end
		// Capture pulse counts in capture mode
		ahb(isf_pkg::H_EVENTS, 1'b1, 32'h3FF7);
		drd(isf_pkg::A_FLAGS1);
		chk(v, 8'hCF);
		drd(isf_pkg::A_FLAGS2);
		chk(v, 8'hFF);
		dwr(isf_pkg::A_FLAGS2, 8'h00);
		dwr(isf_pkg::A_FLAGS1, 8'h00);
		// Compare pulse must be ignored in capture mode
		ahb(isf_pkg::H_EVENTS, 1'b1, 32'h08);
		drd(isf_pkg::A_FLAGS1);
		chk(v, 8'h80);
		ahb(isf_pkg::H_LEVELS, 1'b1, 32'h0000A51E);
		// Read-only view bits ignore the write; capture ignored in compare mode
		dwr(isf_pkg::A_FLAGS1, 8'h80);
		ahb(isf_pkg::H_EVENTS, 1'b1, 32'h04);
		drd(isf_pkg::A_FLAGS1);
		chk(v, 8'h30);
		ahb(isf_pkg::H_EVENTS, 1'b1, 32'h08);
		drd(isf_pkg::A_FLAGS1);
		chk(v, 8'h34);
		drd(isf_pkg::A_RXDATA);
		chk(v, 8'hA5);
		ahb(isf_pkg::H_LEVELS, 1'b0, 32'h0);
		chk(r, 32'h0000A51A);
		drd(isf_pkg::A_FLAGS1);
		chk(v, 8'h14);
		dwr(isf_pkg::A_FLAGS1, 8'h00);
		// Group enable off: pending flag must not vector
		dwr(isf_pkg::A_ENAB1, 8'h03);
		dwr(isf_pkg::A_INT_CTRL, 8'h80);
		ahb(isf_pkg::H_EVENTS, 1'b1, 32'h20);
		repeat (40) @(posedge hclk);
		chk(irq_cnt, 0);
		dwr(isf_pkg::A_INT_CTRL, 8'hC0);
		wirq(1);
		drd(isf_pkg::A_INT_CTRL);
		chk(v, 8'h40);
		dwr(isf_pkg::A_FLAGS1, 8'h00);
		ahb(isf_pkg::H_EVENTS, 1'b1, 32'h10);
		repeat (40) @(posedge hclk);
		chk(irq_cnt, 1);
		ahb(isf_pkg::H_OP, 1'b1, 32'h1);
		wirq(2);
		dwr(isf_pkg::A_FLAGS1, 8'h00);
		ahb(isf_pkg::H_OP, 1'b1, 32'h1);
		repeat (40) @(posedge hclk);
		drd(isf_pkg::A_INT_CTRL);
		chk(v, 8'hC0);
		chk(irq_cnt, 2);
		dwr(isf_pkg::A_INT_CTRL, 8'hD0);
		ahb(isf_pkg::H_LEVELS, 1'b1, 32'h19);
		wirq(3);
		drd(isf_pkg::A_INT_CTRL);
		chk(v, 8'h52);
		ahb(isf_pkg::H_LEVELS, 1'b1, 32'h18);
		dwr(isf_pkg::A_INT_CTRL, 8'hC0);
		ahb(isf_pkg::H_OP, 1'b1, 32'h2);
		repeat (16) @(posedge hclk);
		ahb(isf_pkg::H_STATUS, 1'b0, 32'h0);
		chk(r[17], 1'b1);
		ahb(isf_pkg::H_EVENTS, 1'b1, 32'h20);
		wirq(4);
		ahb(isf_pkg::H_STATUS, 1'b0, 32'h0);
		chk(r[17], 1'b0);
		ahb(8'h40, 1'b0, 32'h0);
		chk(r, 32'h0);
		hresetn <= 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		drd(isf_pkg::A_INT_CTRL);
		chk(v, 8'h00);
		drd(isf_pkg::A_ENAB1);
		chk(v, 8'h00);
		print_verdict;
	end
endmodule
